/* File: hdl/rsd_front.sv */
// Link front end: synchronises bus pins, finds clock edges and sequence starts
`timescale 1ns/1ns
module rsd_front (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  rsd_link_if.front lnk
);
  logic [1:0] sclk_sync_reg, sclk_sync_next;
  logic [1:0] sdat_sync_reg, sdat_sync_next;
  logic sclk_d_reg, sclk_d_next;
  logic sdat_d_reg, sdat_d_next;

  // Two-stage synchronisers, second stage only feeds logic
  always_comb begin
    sclk_sync_next = {sclk_sync_reg[0], sclk_i};
    sdat_sync_next = {sdat_sync_reg[0], sdata_i};
    sclk_d_next = sclk_sync_reg[1];
    sdat_d_next = sdat_sync_reg[1];
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_sync_reg <= 2'h0;
      sdat_sync_reg <= 2'h0;
      sclk_d_reg <= 1'b0;
      sdat_d_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= sclk_sync_next;
      sdat_sync_reg <= sdat_sync_next;
      sclk_d_reg <= sclk_d_next;
      sdat_d_reg <= sdat_d_next;
    end
  end

  // Start condition: data rises while the clock is low
  assign lnk.clk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
  assign lnk.clk_fall = ~sclk_sync_reg[1] & sclk_d_reg;
  assign lnk.sdata = sdat_sync_reg[1];
  assign lnk.ssc = ~sclk_sync_reg[1] & ~sclk_d_reg & sdat_sync_reg[1] & ~sdat_d_reg;
endmodule : rsd_front

/* File: hdl/rsd_jump.sv */
// Next-address evaluation for extended accesses with channel skipping
`timescale 1ns/1ns
module rsd_jump
  import rsd_pkg::*;
(
  input wire logic [5:0] addr_i,
  input wire logic jump_en_i,
  input wire logic [7:0] route_i,
  input wire logic [1:0] frame_sel_i,
  output logic [5:0] next_addr_o,
  output logic drop_o
);
  // True when a channel address is reachable under the frame's identifier
  function automatic logic reachable(input logic [5:0] a, input logic [7:0] rt,
                                     input logic [1:0] sel);
    logic [1:0] r;
    r = 2'h0;
    if (a < ADDR_CH_A || a > ADDR_CH_D) begin
      reachable = 1'b1;
    end else begin
      r = rt[2*(a-ADDR_CH_A) +: 2];
      reachable = (r == 2'h3) || (r == sel);
    end
  endfunction : reachable

  // Walk at most four addresses; land on the fourth if none is reachable
  always_comb begin
    next_addr_o = addr_i + 6'h01;
    drop_o = 1'b0;
    if (jump_en_i) begin
      if (reachable(addr_i + 6'h01, route_i, frame_sel_i)) begin
        next_addr_o = addr_i + 6'h01;
      end else if (reachable(addr_i + 6'h02, route_i, frame_sel_i)) begin
        next_addr_o = addr_i + 6'h02;
      end else if (reachable(addr_i + 6'h03, route_i, frame_sel_i)) begin
        next_addr_o = addr_i + 6'h03;
      end else begin
        next_addr_o = addr_i + 6'h04;
        drop_o = ~reachable(addr_i + 6'h04, route_i, frame_sel_i);
      end
    end
  end
endmodule : rsd_jump

/* File: hdl/rsd_link_if.sv */
// Interface carrying sampled link events from front end to decoder
`timescale 1ns/1ns
interface rsd_link_if;
  logic clk_rise;
  logic clk_fall;
  logic sdata;
  logic ssc;
  modport front (output clk_rise, output clk_fall, output sdata, output ssc);
  modport core (input clk_rise, input clk_fall, input sdata, input ssc);
endinterface : rsd_link_if

/* File: hdl/rsd_pkg.sv */
// Package of constants and types for the serial-bus slave command decoder
package rsd_pkg;
  // Frame and field widths
  localparam int unsigned SID_W = 4;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned NREG = 64;
  // Register addresses used by the decoder
  localparam logic [5:0] ADDR_REG0 = 6'h00;
  localparam logic [5:0] ADDR_CH_A = 6'h06;
  localparam logic [5:0] ADDR_CH_D = 6'h09;
  localparam logic [5:0] ADDR_PMODE = 6'h1C;
  localparam logic [5:0] ADDR_PART_ID = 6'h1D;
  localparam logic [5:0] ADDR_MAKER_ID = 6'h1E;
  localparam logic [5:0] ADDR_SID0 = 6'h1F;
  localparam logic [5:0] ADDR_SID1 = 6'h18;
  localparam logic [5:0] ADDR_SID2 = 6'h19;
  localparam logic [5:0] ADDR_ROUTE = 6'h05;
  localparam logic [5:0] ADDR_SINGLE_MAX = 6'h1F;
  // Field positions
  localparam int unsigned JUMP_EN_BIT = 7;
  localparam int unsigned GLIDE_BIT = 7;
  localparam logic [3:0] SID_UPPER_PATTERN = 4'h1;
  localparam logic [3:0] BROADCAST_SID = 4'h0;
  localparam int unsigned JUMP_MAX = 4;
  // Reset values of identifiers
  localparam logic [3:0] SID0_RESET = 4'h7;
  localparam logic [3:0] SID1_RESET = 4'h8;
  localparam logic [3:0] SID2_RESET = 4'h9;
  // Arbitrary neutral identification values
  localparam logic [7:0] PART_ID_VAL = 8'h5A;
  localparam logic [7:0] MAKER_ID_VAL = 8'hA5;
  // Power modes
  localparam logic [1:0] PM_ACTIVE = 2'h0;
  localparam logic [1:0] PM_STARTUP = 2'h1;
  localparam logic [1:0] PM_LOWPWR = 2'h2;
  localparam logic [1:0] PM_RESERVED = 2'h3;
  // Command classes
  typedef enum logic [4:0] {
    CMD_NONE = 5'h01,
    CMD_REG0 = 5'h02,
    CMD_WR = 5'h04,
    CMD_RD = 5'h08,
    CMD_EXT = 5'h10
  } rsd_cmd_e;
endpackage : rsd_pkg

/* File: hdl/rsd_top.sv */
// Serial-bus slave command decoder with register store and identifier change
`timescale 1ns/1ns
//
// Contract
// RULE1: Register 0 write stores seven bits
// RULE2: Single write reaches addresses zero to 31
// RULE3: Channel byte splits glide and code
// RULE4: Power mode from two top bits
// RULE5: Extended write covers bursts and upper range
// RULE6: Byte count is field plus one
// RULE7: Burst address increments per byte
// RULE8: Four channels loadable in one burst
// RULE9: Reads answer all 64 addresses
// RULE10: Jump only when enable bit set
// RULE11: Jump checks routing against frame identifier
// RULE12: Jump spans four, drops write there
// RULE13: Routing three never skipped
// RULE14: Routing zero to two skipped on mismatch
// RULE15: Master targets at least one reachable channel
// RULE16: Identifier change by broadcast or own identifier
// RULE17: Same maker and part values for all
// RULE18: New identifier needs pattern one upper nibble
// RULE19: Identifiers reset on shutdown mode
// RULE20: Odd parity per frame, bus park end
// RULE21: Drive data only for read bits
module rsd_top
  import rsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic shutdown_i,
  output logic sdata_o,
  output logic sdata_oe_o,
  output logic [6:0] code_a_o,
  output logic [6:0] code_b_o,
  output logic [6:0] code_c_o,
  output logic [6:0] code_d_o,
  output logic glide_enable_a_o,
  output logic glide_enable_b_o,
  output logic glide_enable_c_o,
  output logic glide_enable_d_o,
  output logic [1:0] power_mode_o,
  output logic [3:0] slave_identifier_zero_o,
  output logic [3:0] slave_identifier_one_o,
  output logic [3:0] slave_identifier_two_o
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_DATA = 7'h08,
    ST_RPARK = 7'h10,
    ST_RDATA = 7'h20,
    ST_PARK = 7'h40
  } rsd_state_e;

  rsd_link_if lnk ();
  rsd_front u_front (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .lnk(lnk)
  );

  logic [7:0] regs_reg [NREG];
  logic [7:0] regs_next [NREG];
  rsd_state_e st_reg, st_next;
  logic [12:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [4:0] bits_reg, bits_next;
  logic [5:0] addr_reg, addr_next;
  logic [3:0] sid_reg, sid_next;
  logic [1:0] sel_reg, sel_next;
  rsd_cmd_e cmd_reg, cmd_next;
  logic ext_rd_reg, ext_rd_next;
  logic drop_reg, drop_next;
  logic [8:0] rd_sh_reg, rd_sh_next;
  logic oe_reg, oe_next;
  logic dout_reg, dout_next;
  logic [1:0] pmode_reg, pmode_next;
  logic [3:0] sid0_reg, sid0_next, sid1_reg, sid1_next, sid2_reg, sid2_next;
  logic unlock_reg, unlock_next;
  logic [5:0] j_next_addr;
  logic j_drop;

  // Jump evaluator driven by routing register and frame identifier
  rsd_jump u_jump (
    .addr_i(addr_reg),
    .jump_en_i(regs_reg[ADDR_REG0][JUMP_EN_BIT]), // RULE10
    .route_i(regs_reg[ADDR_ROUTE]),
    .frame_sel_i(sel_reg), // RULE11
    .next_addr_o(j_next_addr),
    .drop_o(j_drop)
  );

  // Odd parity check over a frame plus its parity bit
  function automatic logic par_ok(input logic [8:0] f);
    par_ok = ^f;
  endfunction : par_ok

  // Register read image, identifiers and ID values live outside the array
  function automatic logic [7:0] rd_val(input logic [5:0] a, input logic [7:0] r);
    case (a)
      ADDR_SID0: rd_val = {SID_UPPER_PATTERN, sid0_reg};
      ADDR_SID1: rd_val = {SID_UPPER_PATTERN, sid1_reg};
      ADDR_SID2: rd_val = {SID_UPPER_PATTERN, sid2_reg};
      ADDR_PART_ID: rd_val = PART_ID_VAL;
      ADDR_MAKER_ID: rd_val = MAKER_ID_VAL;
      ADDR_PMODE: rd_val = {pmode_reg, 6'h00};
      default: rd_val = r;
    endcase
  endfunction : rd_val

  // Frame sequencer: sample on falling edge, drive on rising edge
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    bits_next = bits_reg;
    addr_next = addr_reg;
    sid_next = sid_reg;
    sel_next = sel_reg;
    cmd_next = cmd_reg;
    ext_rd_next = ext_rd_reg;
    drop_next = drop_reg;
    rd_sh_next = rd_sh_reg;
    oe_next = oe_reg;
    dout_next = dout_reg;
    pmode_next = pmode_reg;
    sid0_next = sid0_reg;
    sid1_next = sid1_reg;
    sid2_next = sid2_reg;
    unlock_next = unlock_reg;
    for (int i = 0; i < NREG; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (lnk.ssc) begin
      st_next = ST_CMD;
      bits_next = 5'h00;
      oe_next = 1'b0;
    end else if (lnk.clk_fall) begin
      sh_next = {sh_reg[11:0], lnk.sdata};
      bits_next = (st_reg == ST_RDATA) ? bits_reg : bits_reg + 5'h01; // Reads count rises only
      case (st_reg)
        ST_CMD: begin
          if (bits_reg == 5'd12) begin
            bits_next = 5'h00;
            sid_next = sh_reg[11:8];
            // Identifier that the frame used decides routing match
            if (sh_reg[11:8] == sid1_reg) sel_next = 2'h1;
            else if (sh_reg[11:8] == sid2_reg) sel_next = 2'h2;
            else sel_next = 2'h0;
            if (!(^{sh_reg[11:0], lnk.sdata}) ||
                !(sh_reg[11:8] == sid0_reg || sh_reg[11:8] == sid1_reg ||
                  sh_reg[11:8] == sid2_reg || sh_reg[11:8] == BROADCAST_SID)) begin
              st_next = ST_IDLE; // RULE20
            end else if (sh_reg[7]) begin
              regs_next[ADDR_REG0] = {1'b0, sh_reg[6:0]}; // RULE1
              st_next = ST_PARK;
            end else if (sh_reg[6]) begin
              cmd_next = sh_reg[5] ? CMD_RD : CMD_WR;
              addr_next = {1'b0, sh_reg[4:0]}; // RULE2
              cnt_next = 4'h0;
              st_next = sh_reg[5] ? ST_RPARK : ST_DATA;
              drop_next = 1'b0;
            end else if (sh_reg[7:5] == 3'h0) begin
              cmd_next = CMD_EXT;
              ext_rd_next = sh_reg[4];
              cnt_next = sh_reg[3:0]; // RULE6
              st_next = ST_ADDR;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
        ST_ADDR: begin
          if (bits_reg == 5'd8) begin
            bits_next = 5'h00;
            addr_next = sh_reg[5:0]; // RULE5
            drop_next = 1'b0;
            if (!par_ok({sh_reg[7:0], lnk.sdata})) st_next = ST_IDLE;
            else st_next = ext_rd_reg ? ST_RPARK : ST_DATA;
          end
        end
        ST_DATA: begin
          if (bits_reg == 5'd8) begin
            bits_next = 5'h00;
            // Writes with bad parity or skipped landing are dropped
            if (par_ok({sh_reg[7:0], lnk.sdata}) && !drop_reg) begin // RULE20 RULE12
              if (addr_reg == ADDR_PMODE) begin
                pmode_next = sh_reg[7:6]; // RULE4
              end else if (addr_reg == ADDR_SID0 || addr_reg == ADDR_SID1 ||
                           addr_reg == ADDR_SID2) begin
                // Change only by broadcast or own identifier, after ID unlock
                if (unlock_reg && sh_reg[7:4] == SID_UPPER_PATTERN) begin // RULE18 RULE17
                  if (addr_reg == ADDR_SID0 &&
                      (sid_reg == BROADCAST_SID || sid_reg == sid0_reg))
                    sid0_next = sh_reg[3:0]; // RULE16
                  if (addr_reg == ADDR_SID1 &&
                      (sid_reg == BROADCAST_SID || sid_reg == sid1_reg))
                    sid1_next = sh_reg[3:0]; // RULE16
                  if (addr_reg == ADDR_SID2 &&
                      (sid_reg == BROADCAST_SID || sid_reg == sid2_reg))
                    sid2_next = sh_reg[3:0]; // RULE16
                end
                unlock_next = 1'b0;
              end else if (addr_reg == ADDR_PART_ID) begin
                unlock_next = (sh_reg[7:0] == PART_ID_VAL); // RULE17
              end else if (addr_reg == ADDR_MAKER_ID) begin
                unlock_next = unlock_reg && (sh_reg[7:0] == MAKER_ID_VAL);
              end else begin
                regs_next[addr_reg] = sh_reg[7:0]; // RULE3 RULE8
              end
            end
            if (cmd_reg == CMD_EXT && cnt_reg != 4'h0) begin
              cnt_next = cnt_reg - 4'h1;
              addr_next = j_next_addr; // RULE7 RULE13 RULE14
              drop_next = j_drop; // RULE12
            end else begin
              st_next = ST_PARK;
            end
          end
        end
        ST_PARK: begin
          st_next = ST_IDLE; // RULE20
          oe_next = 1'b0; // RULE21
        end
        default: st_next = st_reg;
      endcase
    end else if (lnk.clk_rise) begin
      case (st_reg)
        ST_RPARK: begin
          // Master owns the park cycle; drive from the rise after it
          if (bits_reg != 5'h00) begin
            rd_sh_next = {rd_val(addr_reg, regs_reg[addr_reg]),
                          ~^rd_val(addr_reg, regs_reg[addr_reg])}; // RULE9
            dout_next = rd_sh_next[8];
            oe_next = 1'b1; // RULE21
            bits_next = 5'h00;
            st_next = ST_RDATA;
          end
        end
        ST_RDATA: begin
          bits_next = bits_reg + 5'h01;
          rd_sh_next = {rd_sh_reg[7:0], 1'b0};
          dout_next = rd_sh_reg[7];
          if (bits_reg == 5'd8) begin
            if (cmd_reg == CMD_EXT && cnt_reg != 4'h0) begin
              cnt_next = cnt_reg - 4'h1;
              addr_next = j_next_addr; // RULE10
              rd_sh_next = {rd_val(j_next_addr, regs_reg[j_next_addr]),
                            ~^rd_val(j_next_addr, regs_reg[j_next_addr])};
              dout_next = rd_sh_next[8];
              bits_next = 5'h00;
            end else begin
              // Bus park: drive low one cycle then release
              dout_next = 1'b0;
              st_next = ST_PARK;
            end
          end
        end
        default: st_next = st_reg;
      endcase
    end
    // Shutdown drops programmed identifiers
    if (shutdown_i) begin
      sid0_next = SID0_RESET; // RULE19
      sid1_next = SID1_RESET;
      sid2_next = SID2_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= ST_IDLE;
      sh_reg <= 13'h0000;
      cnt_reg <= 4'h0;
      bits_reg <= 5'h00;
      addr_reg <= 6'h00;
      sid_reg <= 4'h0;
      sel_reg <= 2'h0;
      cmd_reg <= CMD_NONE;
      ext_rd_reg <= 1'b0;
      drop_reg <= 1'b0;
      rd_sh_reg <= 9'h000;
      oe_reg <= 1'b0;
      dout_reg <= 1'b0;
      pmode_reg <= PM_STARTUP;
      sid0_reg <= SID0_RESET;
      sid1_reg <= SID1_RESET;
      sid2_reg <= SID2_RESET;
      unlock_reg <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        regs_reg[i] <= 8'h00;
      end
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      bits_reg <= bits_next;
      addr_reg <= addr_next;
      sid_reg <= sid_next;
      sel_reg <= sel_next;
      cmd_reg <= cmd_next;
      ext_rd_reg <= ext_rd_next;
      drop_reg <= drop_next;
      rd_sh_reg <= rd_sh_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      pmode_reg <= pmode_next;
      sid0_reg <= sid0_next;
      sid1_reg <= sid1_next;
      sid2_reg <= sid2_next;
      unlock_reg <= unlock_next;
      for (int i = 0; i < NREG; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // Outputs straight from flip-flops
  assign sdata_o = dout_reg;
  assign sdata_oe_o = oe_reg;
  assign code_a_o = regs_reg[ADDR_CH_A][6:0]; // RULE3
  assign code_b_o = regs_reg[ADDR_CH_A + 6'h01][6:0];
  assign code_c_o = regs_reg[ADDR_CH_A + 6'h02][6:0];
  assign code_d_o = regs_reg[ADDR_CH_D][6:0];
  assign glide_enable_a_o = regs_reg[ADDR_CH_A][GLIDE_BIT];
  assign glide_enable_b_o = regs_reg[ADDR_CH_A + 6'h01][GLIDE_BIT];
  assign glide_enable_c_o = regs_reg[ADDR_CH_A + 6'h02][GLIDE_BIT];
  assign glide_enable_d_o = regs_reg[ADDR_CH_D][GLIDE_BIT];
  assign power_mode_o = pmode_reg;
  assign slave_identifier_zero_o = sid0_reg;
  assign slave_identifier_one_o = sid1_reg;
  assign slave_identifier_two_o = sid2_reg;
endmodule : rsd_top

/* File: tb/rsd_master.sv */
// Bus master model driving the serial clock and data line
`timescale 1ns/1ns
module rsd_master (
  input wire logic clk_i,
  input wire logic sdata_i,
  input wire logic sdata_oe_i,
  output logic sclk_o,
  output logic sdata_o
);
  logic m_d;
  logic m_oe;
  logic pk;
  logic [7:0] dat [16];
  logic dpar [16];
  // Released line sinks to the keeper's low level; a high float would fake a start
  assign sdata_o = sdata_oe_i ? sdata_i : (m_oe ? m_d : 1'b0);
  // Clock stands low and the line is held low between sequences
  initial begin
    sclk_o = 1'b0;
    m_d = 1'b0;
    m_oe = 1'b1;
  end
  // Data moves at the rising edge, slave samples at the falling edge
  task automatic bit_out(input logic b);
    sclk_o = 1'b1;
    m_d = b;
    #80;
    sclk_o = 1'b0;
    #80;
  endtask : bit_out
  task automatic bit_in(output logic b);
    sclk_o = 1'b1;
    #80;
    b = sdata_o;
    sclk_o = 1'b0;
    #80;
  endtask : bit_in
  // Frame sent MSB first with odd parity, optionally spoilt
  task automatic frame(input logic [11:0] v, input int n, input logic bad);
    logic p;
    p = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      p = p ^ v[i];
      bit_out(v[i]);
    end
    bit_out(p ^ bad);
  endtask : frame
  // Whole sequence: start, command, optional address, data, park
  task automatic xfer(input logic [3:0] sid, input logic [7:0] cmd, input logic has_addr,
                      input logic [7:0] addr, input int n, input logic rd, input logic bad);
    @(negedge clk_i);
    m_d = 1'b1;
    #80;
    m_d = 1'b0;
    #80;
    frame({sid, cmd}, 12, 1'b0);
    if (has_addr) frame({4'h0, addr}, 8, 1'b0);
    if (rd) begin
      bit_out(1'b0);
      m_oe = 1'b0;
      for (int i = 0; i < n; i++) begin
        for (int j = 7; j >= 0; j--) bit_in(dat[i][j]);
        bit_in(dpar[i]);
      end
      bit_in(pk);
      m_oe = 1'b1;
    end else begin
      for (int i = 0; i < n; i++) frame({4'h0, dat[i]}, 8, bad);
      bit_out(1'b0);
    end
  endtask : xfer
endmodule : rsd_master

/* File: tb/rsd_top_assertions.sv */
// Concurrent checks on the slave decoder ports
`timescale 1ns/1ns
module rsd_top_assertions
  import rsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic shutdown_i,
  input wire logic sdata_o,
  input wire logic sdata_oe_o,
  input wire logic [6:0] code_a_o,
  input wire logic [6:0] code_b_o,
  input wire logic [6:0] code_c_o,
  input wire logic [6:0] code_d_o,
  input wire logic glide_enable_a_o,
  input wire logic glide_enable_b_o,
  input wire logic glide_enable_c_o,
  input wire logic glide_enable_d_o,
  input wire logic [1:0] power_mode_o,
  input wire logic [3:0] slave_identifier_zero_o,
  input wire logic [3:0] slave_identifier_one_o,
  input wire logic [3:0] slave_identifier_two_o
);
  logic sclk_q;
  logic [5:0] rise_cnt;
  logic [5:0] fall_cnt;
  // Cycles since the last bus clock edge, saturating so idle is visible
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q <= 1'b0;
      rise_cnt <= 6'h3F;
      fall_cnt <= 6'h3F;
    end else begin
      sclk_q <= sclk_i;
      rise_cnt <= (sclk_i && !sclk_q) ? 6'h00 : rise_cnt + {5'h00, rise_cnt != 6'h3F};
      fall_cnt <= (!sclk_i && sclk_q) ? 6'h00 : fall_cnt + {5'h00, fall_cnt != 6'h3F};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_oe_after_rise: assert property ($rose(sdata_oe_o) |-> sclk_i && rise_cnt < 6'h0C)
    else $error("drive enable raised away from a rising bus clock");
  chk_oe_release_fall: assert property ($fell(sdata_oe_o) |-> !sclk_i && fall_cnt < 6'h0C)
    else $error("drive enable released away from a falling bus clock");
  chk_data_after_rise: assert property (sdata_oe_o && $changed(sdata_o) |-> sclk_i && rise_cnt < 6'h0C)
    else $error("driven data moved away from a rising bus clock");
  chk_oe_idle_low: assert property (rise_cnt == 6'h3F |-> !sdata_oe_o)
    else $error("line driven while the bus is idle");
  chk_mode_after_fall: assert property ($changed(power_mode_o) |-> !sclk_i && fall_cnt < 6'h0C)
    else $error("power mode changed without a bus write");
  chk_code_after_fall: assert property ($changed({code_a_o, code_b_o, code_c_o, code_d_o}) |->
    !sclk_i && fall_cnt < 6'h0C) else $error("channel code changed without a bus write");
  chk_glide_after_fall: assert property ($changed({glide_enable_a_o, glide_enable_b_o,
    glide_enable_c_o, glide_enable_d_o}) |-> !sclk_i && fall_cnt < 6'h0C)
    else $error("glide enable changed without a bus write");
  chk_sid_cause: assert property ($changed({slave_identifier_zero_o, slave_identifier_one_o,
    slave_identifier_two_o}) |-> $past(shutdown_i) || $past(shutdown_i, 2) ||
    (!sclk_i && fall_cnt < 6'h0C)) else $error("identifier changed without cause");
  chk_sid_shutdown: assert property (shutdown_i |-> ##[1:3] ({slave_identifier_zero_o,
    slave_identifier_one_o, slave_identifier_two_o} == {SID0_RESET, SID1_RESET, SID2_RESET}))
    else $error("identifiers not restored in shutdown");
endmodule : rsd_top_assertions
bind rsd_top rsd_top_assertions u_rsd_top_assertions (.clk_i, .resetn_i, .sclk_i, .sdata_i,
  .shutdown_i, .sdata_o, .sdata_oe_o, .code_a_o, .code_b_o, .code_c_o, .code_d_o,
  .glide_enable_a_o, .glide_enable_b_o, .glide_enable_c_o, .glide_enable_d_o, .power_mode_o,
  .slave_identifier_zero_o, .slave_identifier_one_o, .slave_identifier_two_o);

/* File: tb/rsd_top_tb.sv */
// Self-checking bench for the serial-bus slave command decoder
`timescale 1ns/1ns
module rsd_top_tb;
  import rsd_pkg::*;
  logic clk_i, resetn_i, shutdown_i, sclk, sdata, sdata_o, sdata_oe_o;
  logic [6:0] code_q [4];
  logic [3:0] glide_q;
  logic [1:0] power_mode_o;
  logic [3:0] sid0, sid1, sid2;
  int num_errors, comparisons;
  rsd_master u_rsd_master (.clk_i(clk_i), .sdata_i(sdata_o), .sdata_oe_i(sdata_oe_o),
    .sclk_o(sclk), .sdata_o(sdata));
  rsd_top u_rsd_top (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .sdata_i(sdata),
    .shutdown_i(shutdown_i), .sdata_o(sdata_o), .sdata_oe_o(sdata_oe_o),
    .code_a_o(code_q[0]), .code_b_o(code_q[1]), .code_c_o(code_q[2]), .code_d_o(code_q[3]),
    .glide_enable_a_o(glide_q[0]), .glide_enable_b_o(glide_q[1]),
    .glide_enable_c_o(glide_q[2]), .glide_enable_d_o(glide_q[3]), .power_mode_o(power_mode_o),
    .slave_identifier_zero_o(sid0), .slave_identifier_one_o(sid1), .slave_identifier_two_o(sid2));
  // Free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Access wrappers; results land in the master's byte array
  task automatic wr(input logic [3:0] s, input logic [5:0] a, input logic [7:0] d, input logic b);
    u_rsd_master.dat[0] = d;
    u_rsd_master.xfer(s, {3'b010, a[4:0]}, 1'b0, 8'h00, 1, 1'b0, b);
  endtask : wr
  task automatic xfr(input logic [3:0] s, input logic [7:0] a, input int n, input logic r);
    u_rsd_master.xfer(s, {3'b000, r, 4'(n - 1)}, 1'b1, a, n, r, 1'b0);
  endtask : xfr
  task automatic ch(input int i, input logic [7:0] e);
    cmp({glide_q[i], code_q[i]}, e);
  endtask : ch
  task automatic keys(input logic [3:0] s);
    wr(s, ADDR_PART_ID, PART_ID_VAL, 1'b0);
    wr(s, ADDR_MAKER_ID, MAKER_ID_VAL, 1'b0);
  endtask : keys
  // Hang guard well beyond the expected run length
  initial begin
    #600000;
    num_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    resetn_i = 1'b0;
    shutdown_i = 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i) resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    cmp({6'h00, power_mode_o}, {6'h00, PM_STARTUP});
    u_rsd_master.xfer(4'h7, 8'h8F, 1'b0, 8'h00, 0, 1'b0, 1'b0);
    u_rsd_master.xfer(4'h7, 8'h60, 1'b0, 8'h00, 1, 1'b1, 1'b0);
    cmp(u_rsd_master.dat[0], 8'h0F);
    cmp({7'h00, u_rsd_master.dpar[0]}, {7'h00, ~^u_rsd_master.dat[0]});
    for (int i = 0; i < 4; i++) wr(4'h7, ADDR_CH_A + 6'(i), 8'(8'h29 + 8'h53 * i), 1'b0);
    for (int i = 0; i < 4; i++) ch(i, 8'(8'h29 + 8'h53 * i));
    wr(4'h7, 6'h11, 8'h3C, 1'b0);
    u_rsd_master.xfer(4'h7, 8'h71, 1'b0, 8'h00, 1, 1'b1, 1'b0);
    cmp(u_rsd_master.dat[0], 8'h3C);
    wr(4'h7, ADDR_CH_A, 8'h55, 1'b1);
    ch(0, 8'h29);
    for (int m = 0; m < 5; m++) begin
      wr(4'h7, ADDR_PMODE, {2'(m), 6'h2A}, 1'b0);
      cmp({6'h00, power_mode_o}, {6'h00, 2'(m)});
    end
    u_rsd_master.dat[0:3] = '{8'h01, 8'h82, 8'h03, 8'hF4};
    xfr(4'h7, 8'h06, 4, 1'b0);
    foreach (u_rsd_master.dat[i]) if (i < 4) ch(i, u_rsd_master.dat[i]);
    for (int i = 0; i < 16; i++) u_rsd_master.dat[i] = 8'(8'h30 + i);
    xfr(4'h7, 8'h30, 16, 1'b0);
    u_rsd_master.dat[0] = 8'hEE;
    xfr(4'h7, 8'h31, 1, 1'b0);
    xfr(4'h7, 8'h30, 3, 1'b1);
    cmp(u_rsd_master.dat[0], 8'h30);
    cmp(u_rsd_master.dat[1], 8'hEE);
    cmp(u_rsd_master.dat[2], 8'h32);
    cmp({7'h00, u_rsd_master.dpar[2]}, {7'h00, ~^u_rsd_master.dat[2]});
    xfr(4'h7, 8'h3F, 1, 1'b1);
    cmp(u_rsd_master.dat[0], 8'h3F);
    cmp({7'h00, sdata_oe_o}, 8'h00);
    wr(4'h7, ADDR_ROUTE, 8'hB1, 1'b0);
    wr(4'h7, ADDR_REG0, 8'h80, 1'b0);
    u_rsd_master.dat[0:1] = '{8'h11, 8'h22};
    xfr(4'h8, 8'h06, 2, 1'b0);
    ch(0, 8'h11);
    ch(1, 8'h82);
    ch(2, 8'h22);
    wr(4'h7, ADDR_ROUTE, 8'h00, 1'b0);
    u_rsd_master.dat[0:1] = '{8'h00, 8'h66};
    xfr(4'h8, 8'h05, 2, 1'b0);
    ch(3, 8'hF4);
    wr(4'h7, ADDR_REG0, 8'h00, 1'b0);
    u_rsd_master.dat[0:1] = '{8'h33, 8'h44};
    xfr(4'h8, 8'h06, 2, 1'b0);
    ch(1, 8'h44);
    keys(4'h8);
    wr(4'h8, ADDR_SID1, 8'h1C, 1'b0);
    cmp({4'h0, sid1}, 8'h0C);
    keys(4'h0);
    wr(4'h0, ADDR_SID2, 8'h13, 1'b0);
    cmp({4'h0, sid2}, 8'h03);
    keys(4'h7);
    wr(4'h7, ADDR_SID0, 8'h2B, 1'b0);
    cmp({4'h0, sid0}, {4'h0, SID0_RESET});
    @(negedge clk_i) shutdown_i = 1'b1;
    repeat (4) @(negedge clk_i);
    shutdown_i = 1'b0;
    cmp({sid1, sid2}, {SID1_RESET, SID2_RESET});
    conclude();
  end
endmodule : rsd_top_tb
